// file: hw/cal_ctrl_pkg.sv
// Constants and types shared by the converter calibration control block.
package cal_ctrl_pkg;

  // ------------------------------------------------------------------
  // Timing counts in sample clock cycles.
  // ------------------------------------------------------------------
  localparam int unsigned REQUEST_HOLD_CYCLES = 640;
  localparam int unsigned START_LAG_CYCLES = 640;
  localparam int unsigned SHORT_DELAY_CYCLES = 4096;
  localparam int unsigned LONG_DELAY_CYCLES = 65536;
  localparam int unsigned CAL_RUN_CYCLES = 1024;
  localparam int unsigned COUNT_WIDTH = 20;

  // ------------------------------------------------------------------
  // Full-scale spans in millivolts.
  // ------------------------------------------------------------------
  localparam logic [9:0] SPAN_HIGH_MV = 10'd870;
  localparam logic [9:0] SPAN_LOW_MV = 10'd650;
  localparam logic [9:0] SPAN_MIN_MV = 10'd560;
  localparam logic [9:0] SPAN_MAX_MV = 10'd840;

  // ------------------------------------------------------------------
  // Sequencer states, Gray coded in the order listed.
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_POWER_WAIT = 3'b000,
    ST_IDLE = 3'b001,
    ST_START_LAG = 3'b011,
    ST_CALIBRATE = 3'b010,
    ST_POWERED_DOWN = 3'b110
  } seq_state_type;

  // ------------------------------------------------------------------
  // Interrupt event bits.
  // ------------------------------------------------------------------
  localparam int unsigned EVENT_CAL_DONE = 0;
  localparam int unsigned EVENT_RANGE = 1;
  localparam int unsigned EVENT_WIDTH = 2;

  // ------------------------------------------------------------------
  // Register offsets.
  // ------------------------------------------------------------------
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_SPAN = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_EVENTS = 4'h3;
  localparam logic [3:0] ADDR_MASK = 4'h4;

  localparam int unsigned CTRL_EXTENDED_BIT = 0;
  localparam logic [9:0] SPAN_RESET_MV = 10'd700;

endpackage : cal_ctrl_pkg

// file: hw/request_qualifier.sv
// Qualifies the calibrate request pin: long low then long high.
`timescale 1ns/1ps
module request_qualifier
  import cal_ctrl_pkg::*;
#(
  parameter int unsigned HOLD = REQUEST_HOLD_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_request,
  input wire logic i_enable,
  output logic o_armed_high,
  output logic o_rise_ok
);

  typedef struct packed {
    logic [10:0] count;
    logic low_ok;
    logic armed_high;
    logic rise_ok;
    logic last;
  } qual_state_type;

  qual_state_type state;
  qual_state_type next_state;

  always_comb begin
    next_state = state;
    next_state.rise_ok = 1'b0;
    next_state.last = i_request;
    if (!i_enable) begin
      next_state = '0;
      next_state.last = i_request;
    end else if (i_request != state.last) begin
      // The sample that shows the new level is the first of its phase.
      next_state.count = 11'h001;
      if (i_request && state.low_ok) begin
        next_state.rise_ok = 1'b1;
      end
      next_state.low_ok = 1'b0;
      next_state.armed_high = 1'b0;
    end else begin
      if (state.count != 11'h7FF) begin
        next_state.count = state.count + 11'h001;
      end
      // A low phase that lasted long enough arms the rising edge.
      if (!i_request && (32'(state.count) + 32'd1 >= HOLD)) begin
        next_state.low_ok = 1'b1;
      end
      if (i_request && (32'(state.count) + 32'd1 >= HOLD)) begin
        next_state.armed_high = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign o_armed_high = state.armed_high;
  assign o_rise_ok = state.rise_ok;

endmodule : request_qualifier

// file: hw/cal_ctrl.sv
// Calibration sequencer, range select and out-of-range flag for the converter.
`timescale 1ns/1ps
module cal_ctrl
  import cal_ctrl_pkg::*;
#(
  parameter int unsigned SHORT_DELAY = SHORT_DELAY_CYCLES,
  parameter int unsigned LONG_DELAY = LONG_DELAY_CYCLES,
  parameter int unsigned CAL_RUN = CAL_RUN_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_request,
  input wire logic i_calibration_delay_select,
  input wire logic i_range_select,
  input wire logic i_power_down_pin,
  input wire logic i_clock_present,
  input wire logic i_over_range,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_calibration_active,
  output logic o_output_data_clock_en,
  output logic o_analog_power_down,
  output logic o_range_p,
  output logic o_range_n,
  output logic [9:0] o_span_mv,
  output logic o_irq
);

  // ------------------------------------------------------------------
  // State record.
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] sync_req;
    logic [1:0] sync_dly;
    logic [1:0] sync_rng;
    logic [1:0] sync_pd;
    logic [1:0] sync_clk;
    logic [1:0] sync_or;
    seq_state_type seq;
    logic [COUNT_WIDTH-1:0] count;
    logic skip_por;
    logic pd_after;
    logic extended;
    logic [9:0] span_prog;
    logic [EVENT_WIDTH-1:0] events;
    logic [EVENT_WIDTH-1:0] mask;
    logic [31:0] rdata;
    logic cal_active;
    logic output_data_clock_en;
    logic analog_pd;
    logic range_p;
    logic range_n;
    logic [9:0] span;
    logic irq;
  } ctrl_state_type;

  ctrl_state_type state;
  ctrl_state_type next_state;
  logic armed_high;
  logic rise_ok;
  logic qual_enable;
  logic [COUNT_WIDTH-1:0] por_delay;
  logic [EVENT_WIDTH-1:0] new_events;
  logic [9:0] wr_span;

  // Request pin is ignored in the powered-down state or while the power-down pin is high.
  assign qual_enable = (state.seq != ST_POWERED_DOWN) && !state.sync_pd[1];

  request_qualifier #(
    .HOLD(REQUEST_HOLD_CYCLES)
  ) u_qual (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_request(state.sync_req[1]),
    .i_enable(qual_enable),
    .o_armed_high(armed_high),
    .o_rise_ok(rise_ok)
  );

  // ------------------------------------------------------------------
  // Next-state logic.
  // ------------------------------------------------------------------
  always_comb begin
    next_state = state;
    new_events = '0;
    wr_span = i_wdata[9:0];
    next_state.sync_req = {state.sync_req[0], i_request};
    next_state.sync_dly = {state.sync_dly[0], i_calibration_delay_select};
    next_state.sync_rng = {state.sync_rng[0], i_range_select};
    next_state.sync_pd = {state.sync_pd[0], i_power_down_pin};
    next_state.sync_clk = {state.sync_clk[0], i_clock_present};
    next_state.sync_or = {state.sync_or[0], i_over_range};
    // The delay length follows the synchronised select only while extended mode is off.
    por_delay = (state.sync_dly[1] && !state.extended) ? COUNT_WIDTH'(LONG_DELAY)
                                                     : COUNT_WIDTH'(SHORT_DELAY);
    if (state.count != '0) begin
      next_state.count = state.count - COUNT_WIDTH'(1);
    end
    case (state.seq)
      ST_POWER_WAIT: begin
        // A request pin seen high while waiting cancels power-on calibration.
        if (state.sync_req[1]) begin
          next_state.skip_por = 1'b1;
        end
        // Delay counter is loaded only once the clock is present and power-down low,
        // so the delay length comes from a settled select input.
        if (!state.sync_clk[1] || state.sync_pd[1]) begin
          next_state.count = '0;
        end else if (state.count == COUNT_WIDTH'(1)) begin
          if (state.skip_por) begin
            next_state.seq = ST_IDLE;
          end else begin
            next_state.seq = ST_CALIBRATE;
            next_state.count = COUNT_WIDTH'(CAL_RUN);
          end
        end else if (state.count == '0) begin
          next_state.count = por_delay;
        end
      end
      ST_IDLE: begin
        if (state.sync_pd[1]) begin
          next_state.seq = ST_POWERED_DOWN;
        end else if (rise_ok) begin
          next_state.seq = ST_START_LAG;
          next_state.count = COUNT_WIDTH'(START_LAG_CYCLES - 1);
        end
      end
      ST_START_LAG: begin
        if (!state.sync_req[1] || state.sync_pd[1]) begin
          next_state.seq = ST_IDLE;
        end else if (state.count == '0 && armed_high) begin
          next_state.seq = ST_CALIBRATE;
          next_state.count = COUNT_WIDTH'(CAL_RUN);
        end
      end
      ST_CALIBRATE: begin
        if (state.sync_pd[1]) begin
          next_state.pd_after = 1'b1;
        end
        if (state.count == COUNT_WIDTH'(1)) begin
          new_events[EVENT_CAL_DONE] = 1'b1;
          next_state.seq = (state.pd_after || state.sync_pd[1]) ? ST_POWERED_DOWN
                                                               : ST_IDLE;
          next_state.pd_after = 1'b0;
        end
      end
      ST_POWERED_DOWN: begin
        if (!state.sync_pd[1]) begin
          next_state.seq = ST_IDLE;
        end
      end
      default: begin
        next_state.seq = ST_IDLE;
      end
    endcase
    // Calibration flag and data clock enable are both decoded from the next sequencer state.
    next_state.cal_active = (next_state.seq == ST_CALIBRATE);
    next_state.output_data_clock_en = (next_state.seq == ST_IDLE) || (next_state.seq == ST_START_LAG);
    next_state.analog_pd = (next_state.seq == ST_POWERED_DOWN)
                           || ((next_state.seq == ST_POWER_WAIT) && !state.sync_clk[1]);
    next_state.range_p = state.sync_or[1];
    next_state.range_n = !state.sync_or[1];
    if (state.sync_or[1] && !state.range_p) begin
      new_events[EVENT_RANGE] = 1'b1;
    end
    if (state.extended) begin
      next_state.span = state.span_prog;
    end else begin
      next_state.span = state.sync_rng[1] ? SPAN_HIGH_MV : SPAN_LOW_MV;
    end
    // Register writes; an event in the clear cycle survives.
    if (i_wr) begin
      case (i_addr)
        ADDR_CONTROL: next_state.extended = i_wdata[CTRL_EXTENDED_BIT];
        ADDR_SPAN: begin
          if (wr_span < SPAN_MIN_MV) begin
            next_state.span_prog = SPAN_MIN_MV;
          end else if (wr_span > SPAN_MAX_MV) begin
            next_state.span_prog = SPAN_MAX_MV;
          end else begin
            next_state.span_prog = wr_span;
          end
        end
        ADDR_EVENTS: next_state.events = state.events & ~i_wdata[EVENT_WIDTH-1:0];
        ADDR_MASK: next_state.mask = i_wdata[EVENT_WIDTH-1:0];
        default: begin
        end
      endcase
    end
    next_state.events = next_state.events | new_events;
    next_state.irq = |(next_state.events & next_state.mask);
    next_state.rdata = 32'h0000_0000;
    if (i_rd) begin
      case (i_addr)
        ADDR_CONTROL: next_state.rdata = {31'h0000_0000, state.extended};
        ADDR_SPAN: next_state.rdata = {22'h00_0000, state.span};
        ADDR_STATUS: next_state.rdata = {25'h000_0000, state.seq, state.range_p,
                                         state.output_data_clock_en, state.analog_pd, state.cal_active};
        ADDR_EVENTS: next_state.rdata = {30'h0000_0000, state.events};
        ADDR_MASK: next_state.rdata = {30'h0000_0000, state.mask};
        default: next_state.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // State register; request level reaches sync_req[1] two cycles after reset.
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      state <= '0;
      state.seq <= ST_POWER_WAIT;
      state.span_prog <= SPAN_RESET_MV;
      state.span <= SPAN_LOW_MV;
      state.range_n <= 1'b1;
      state.analog_pd <= 1'b1;
      state.count <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign o_rdata = state.rdata;
  assign o_calibration_active = state.cal_active;
  assign o_output_data_clock_en = state.output_data_clock_en;
  assign o_analog_power_down = state.analog_pd;
  assign o_range_p = state.range_p;
  assign o_range_n = state.range_n;
  assign o_span_mv = state.span;
  assign o_irq = state.irq;

  // ------------------------------------------------------------------
  // Assertions.
  // ------------------------------------------------------------------
  a_range_pair: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    o_range_p != o_range_n) else $error("range pair not complementary");
  a_range_follow: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    $rose(state.sync_or[1]) |=> o_range_p) else $error("range flag late");
  a_span_normal: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    !state.extended && $past(!state.extended) && $past(state.sync_rng[1]) |->
    o_span_mv == SPAN_HIGH_MV || !$past(i_rstn)) else $error("span not high");
  a_span_bound: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    state.span_prog >= SPAN_MIN_MV && state.span_prog <= SPAN_MAX_MV
    || state.span_prog == SPAN_RESET_MV) else $error("span out of bounds");
  a_cal_clock: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    o_calibration_active |-> !o_output_data_clock_en) else $error("clock during cal");
  a_done_same: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    $fell(o_calibration_active) && state.seq == ST_IDLE |-> o_output_data_clock_en)
    else $error("clock not restored");
  a_pd_defer: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    state.seq == ST_CALIBRATE && state.count > COUNT_WIDTH'(2) |=>
    state.seq == ST_CALIBRATE) else $error("cal cut short");
  a_pd_ignore: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    state.seq == ST_POWERED_DOWN |=> state.seq != ST_START_LAG &&
    state.seq != ST_CALIBRATE) else $error("request taken in power down");
  a_lag_len: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    $rose(state.seq == ST_START_LAG) |=> state.seq != ST_CALIBRATE [*8])
    else $error("cal started early");
  a_cal_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    state.seq == ST_CALIBRATE && $past(state.seq == ST_CALIBRATE) |->
    o_calibration_active) else $error("cal flag low");

endmodule : cal_ctrl

// file: verif/cal_host_model.sv
// Host controller model that drives the calibrate request pin.
`timescale 1ns/1ps
module cal_host_model (
  input wire logic i_clk_sys,
  input wire logic i_go,
  input wire logic i_idle,
  input wire logic [15:0] i_low,
  input wire logic [15:0] i_high,
  output logic o_request,
  output logic o_busy
);
  logic [16:0] count;
  initial begin
    o_request = 1'b0;
    o_busy = 1'b0;
    count = 17'h0;
  end
  // Each go pulse drives the pin low for i_low cycles, high for i_high cycles, then to i_idle.
  always @(posedge i_clk_sys) begin
    if (i_go) begin
      count <= 17'h0;
      o_busy <= 1'b1;
      o_request <= 1'b0;
    end else if (o_busy) begin
      count <= count + 17'h1;
      if (count + 17'h1 < {1'b0, i_low}) begin
        o_request <= 1'b0;
      end else if (count + 17'h1 < {1'b0, i_low} + {1'b0, i_high}) begin
        o_request <= 1'b1;
      end else begin
        o_request <= i_idle;
        o_busy <= 1'b0;
      end
    end else begin
      o_request <= i_idle;
    end
  end
endmodule : cal_host_model

// file: verif/adc_calibration_control_test.sv
// Self-checking testbench of the converter calibration control block.
`timescale 1ns/1ps
module adc_calibration_control_test;
  import cal_ctrl_pkg::*;
  localparam int unsigned SD = 50;
  localparam int unsigned LD = 100;
  localparam int unsigned CR = 20;
  typedef struct {logic rs; logic ovr; logic [9:0] span; logic p; logic n;} row_type;
  row_type rows[4] = '{'{0, 0, SPAN_LOW_MV, 0, 1}, '{1, 0, SPAN_HIGH_MV, 0, 1},
                       '{1, 1, SPAN_HIGH_MV, 1, 0}, '{0, 1, SPAN_LOW_MV, 1, 0}};
  logic [9:0] span_wr[3] = '{10'h2BC, 10'h384, 10'h1F4};
  logic [9:0] span_exp[3] = '{10'h2BC, SPAN_MAX_MV, SPAN_MIN_MV};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic req;
  logic dsel = 1'b0;
  logic rsel = 1'b0;
  logic pd = 1'b0;
  logic cpres = 1'b1;
  logic ovr = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic cal_act, output_data_clock_en, apd, rng_p, rng_n, irq, h_busy;
  logic [9:0] span;
  logic h_go = 1'b0;
  logic h_idle = 1'b0;
  logic [15:0] h_low = 16'h0;
  logic [15:0] h_high = 16'h0;
  logic [31:0] d;
  int fails = 0;
  int comparisons = 0;

  always #10 clk = ~clk;

  cal_ctrl #(.SHORT_DELAY(SD), .LONG_DELAY(LD), .CAL_RUN(CR)) u_dut (
    .i_clk_sys(clk), .i_rstn(rstn), .i_request(req), .i_calibration_delay_select(dsel),
    .i_range_select(rsel), .i_power_down_pin(pd), .i_clock_present(cpres),
    .i_over_range(ovr), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_calibration_active(cal_act), .o_output_data_clock_en(output_data_clock_en),
    .o_analog_power_down(apd), .o_range_p(rng_p), .o_range_n(rng_n), .o_span_mv(span),
    .o_irq(irq));

  cal_host_model u_host (.i_clk_sys(clk), .i_go(h_go), .i_idle(h_idle), .i_low(h_low),
    .i_high(h_high), .o_request(req), .o_busy(h_busy));

  // ------------------------------------------------------------------
  // Shared tasks.
  // ------------------------------------------------------------------
  task check_bit(input logic got, input logic exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t %s", $time, msg);
    end
  endtask : check_bit

  task check_vec(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t %s got %h", $time, msg, got);
    end
  endtask : check_vec

  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task do_reset;
    @(posedge clk);
    rstn <= 1'b0;
    tick(4);
    check_vec({16'h0, cal_act, output_data_clock_en, apd, rng_p, rng_n, irq, span},
              {16'h0, 6'b001010, SPAN_LOW_MV}, "reset outputs");
    @(posedge clk);
    rstn <= 1'b1;
    #1;
  endtask : do_reset

  task reg_write(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : reg_write

  task reg_read(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : reg_read

  task host_seq(input logic [15:0] lo, input logic [15:0] hi, input logic idle);
    int n;
    n = 0;
    @(posedge clk);
    h_low <= lo;
    h_high <= hi;
    h_idle <= idle;
    h_go <= 1'b1;
    @(posedge clk);
    h_go <= 1'b0;
    #1;
    while (h_busy === 1'b1 && n < 5000) begin
      tick(1);
      n++;
    end
  endtask : host_seq

  task wait_start(input int lo, input int hi);
    int n;
    n = 0;
    while (cal_act !== 1'b1 && n <= hi) begin
      tick(1);
      n++;
    end
    check_bit(n >= lo && n <= hi, 1'b1, "calibration start time");
  endtask : wait_start

  task check_run(input logic output_data_clock_after, input int first);
    int n;
    n = first;
    while (cal_act === 1'b1 && n < 3000) begin
      check_bit(output_data_clock_en, 1'b0, "data clock during calibration");
      tick(1);
      n++;
    end
    check_bit(n == CR, 1'b1, "calibration length");
    check_bit(output_data_clock_en, output_data_clock_after, "data clock after calibration");
  endtask : check_run

  task no_cal(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      tick(1);
      if (cal_act !== 1'b0) seen = 1'b1;
    end
    check_bit(seen, 1'b0, "unexpected calibration");
  endtask : no_cal

  task stop_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  // ------------------------------------------------------------------
  // Main sequence.
  // ------------------------------------------------------------------
  initial begin
    do_reset();
    wait_start(SD - 1, SD + 8);
    check_run(1'b1, 0);
    reg_read(ADDR_EVENTS, d);
    check_vec(d, 32'h1, "calibration done event");
    reg_write(ADDR_MASK, 32'h3);
    tick(2);
    check_bit(irq, 1'b1, "interrupt on pending event");
    reg_write(ADDR_EVENTS, 32'h1);
    tick(2);
    check_bit(irq, 1'b0, "interrupt after clear");
    foreach (rows[i]) begin
      @(posedge clk);
      rsel <= rows[i].rs;
      ovr <= rows[i].ovr;
      tick(5);
      check_vec({22'h0, span}, {22'h0, rows[i].span}, "pin span");
      check_bit(rng_p, rows[i].p, "range positive leg");
      check_bit(rng_n, rows[i].n, "range negative leg");
    end
    @(posedge clk);
    ovr <= 1'b0;
    reg_read(ADDR_EVENTS, d);
    check_vec(d, 32'h2, "out of range event");
    reg_write(ADDR_EVENTS, 32'h2);
    reg_read(4'hF, d);
    check_vec(d, 32'h0, "unmapped read");
    reg_write(ADDR_CONTROL, 32'h1);
    rsel <= 1'b1;
    foreach (span_wr[i]) begin
      reg_write(ADDR_SPAN, {22'h0, span_wr[i]});
      tick(3);
      check_vec({22'h0, span}, {22'h0, span_exp[i]}, "programmed span");
    end
    reg_write(ADDR_CONTROL, 32'h0);
    tick(3);
    check_vec({22'h0, span}, {22'h0, SPAN_HIGH_MV}, "pin span restored");
    host_seq(16'd640, 16'd1, 1'b1);
    wait_start(639, 648);
    check_run(1'b1, 0);
    host_seq(16'd300, 16'd1, 1'b1);
    no_cal(1400);
    host_seq(16'd640, 16'd300, 1'b0);
    no_cal(1000);
    host_seq(16'd640, 16'd1, 1'b1);
    wait_start(639, 648);
    @(posedge clk);
    pd <= 1'b1;
    #1;
    check_run(1'b0, 1);
    tick(4);
    check_bit(apd, 1'b1, "power down after calibration");
    host_seq(16'd640, 16'd1, 1'b1);
    no_cal(1000);
    @(posedge clk);
    pd <= 1'b0;
    h_idle <= 1'b0;
    dsel <= 1'b1;
    do_reset();
    wait_start(LD - 1, LD + 8);
    check_run(1'b1, 0);
    @(posedge clk);
    h_idle <= 1'b1;
    dsel <= 1'b0;
    do_reset();
    no_cal(300);
    host_seq(16'd640, 16'd1, 1'b1);
    wait_start(639, 648);
    check_run(1'b1, 0);
    @(posedge clk);
    h_idle <= 1'b0;
    cpres <= 1'b0;
    do_reset();
    no_cal(200);
    check_bit(apd, 1'b1, "analog held down without clock");
    @(posedge clk);
    cpres <= 1'b1;
    wait_start(SD - 1, SD + 12);
    check_run(1'b1, 0);
    stop_test();
  end

  initial begin
    #(40000 * 20);
    fails++;
    $display("BAD t=%0t watchdog expired", $time);
    stop_test();
  end
endmodule : adc_calibration_control_test
